//--- bwc_pkg.sv
// Constants and carrier types for the black/white calibration control bank
package bwc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CLAMP    = 8'h24;
  localparam logic [7:0] OFS_THR_HI   = 8'h25;
  localparam logic [7:0] OFS_THR_LO   = 8'h26;
  localparam logic [7:0] OFS_FAST     = 8'h27;
  localparam logic [7:0] OFS_WCFG     = 8'h28;
  localparam logic [7:0] OFS_RUN_AVG  = 8'h29;
  localparam logic [7:0] OFS_ST_HI    = 8'h2a;
  localparam logic [7:0] OFS_ST_LO    = 8'h2b;
  localparam logic [7:0] OFS_WID_HI   = 8'h2c;
  localparam logic [7:0] OFS_WID_LO   = 8'h2d;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CLAMP    = 8'h84;
  localparam logic [7:0] RST_THR_HI   = 8'h50;
  localparam logic [7:0] RST_THR_LO   = 8'h40;
  localparam logic [7:0] RST_FAST     = 8'h88;
  localparam logic [7:0] RST_WCFG     = 8'h00;
  localparam logic [7:0] RST_RUN_AVG  = 8'h04;
  localparam logic [7:0] RST_ST       = 8'h00;
  localparam logic [7:0] RST_WID      = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_INCR      = 7;
  localparam int BIT_USE_BLK   = 6;
  localparam int BIT_TRIG_SEL  = 5;
  localparam int BIT_PIN_DIS   = 4;
  localparam int BIT_ENABLE    = 0;
  localparam logic [7:0] WCFG_MASK   = 8'hf1;
  localparam logic [7:0] THR_LO_MASK = 8'hc0;
  localparam logic [2:0] RUN_AVG_MAX = 3'h5;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } bwc_req_t;

  // Pins driven by the timing controller
  typedef struct packed {
    logic line_clamp_pin;
    logic black_clamp_pin;
    logic white_loop_start;
    logic pix_en;
  } bwc_pins_t;

  typedef enum logic [1:0] {PK_IDLE, PK_WAIT, PK_WINDOW} bwc_phase_t;

endpackage : bwc_pkg

//--- bwc_ctrl.sv
// Black/white calibration control registers and peak-window sequencer
// What this block does
// - Bits 7:3 of the clamp register select black-clamp averaging length.
// - Coarse DAC step is compensated by threshold on fine DAC, default 321.
// - Threshold bits 9:2 in high register, bits 1:0 in low bits 7:6.
// - Fast-mode register holds hysteresis in 7:5 and threshold in 4:0.
// - White-config bit 7 picks incremental search, else binary search.
// - Bit 6 set subtracts black average from white samples.
// - Bit 5 picks black-clamp pin, else line-clamp pin, as line trigger.
// - Bit 4 set makes the device ignore the white-loop start pin.
// - Writing bit 0 as 1 enables the loop; it reads 1 until ready.
// - Peak average code 0..5 means 1 to 32 pixels, doubling each step.
// - Peak detection starts a 16-bit pixel count after trigger rising edge.
// - Peak detection lasts a 16-bit pixel count from the start pixel.
// - White loop runs continuously while the start pin is held high and bit 4 is clear.
// - Black-loop mode bit 1 updates fine only, else coarse and fine.
`timescale 1ns/10ps
module bwc_ctrl (
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire logic               CE,
  input  wire bwc_pkg::bwc_req_t  REQ,
  input  wire bwc_pkg::bwc_pins_t PINS,
  input  wire logic               LOOP_DONE,
  input  wire logic               BLK_FINE_ONLY,
  input  wire logic [9:0]         SAMPLE_IN,
  input  wire logic [9:0]         BLACK_AVG,
  output logic [7:0]              RDATA,
  output logic [4:0]              CLAMP_AVG_CODE,
  output logic [9:0]              FINE_STEP,
  output logic [2:0]              FAST_HYST,
  output logic [4:0]              FAST_THRESH,
  output logic                    INCR_SEARCH,
  output logic                    UPDATE_COARSE,
  output logic                    WHITE_LOOP_RUN,
  output logic [5:0]              PEAK_AVG_PIXELS,
  output logic                    PEAK_ACTIVE,
  output logic [9:0]              WHITE_SAMPLE
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]          clamp;
    logic [7:0]          thr_hi;
    logic [9:0]          thr;
    logic [7:0]          fast;
    logic [7:0]          wcfg;
    logic [2:0]          run_avg;
    logic [7:0]          st_hi;
    logic [15:0]         st;
    logic [7:0]          wid_hi;
    logic [15:0]         wid;
    logic [7:0]          rdata;
    logic                trig_d;
    logic                run;
    logic                coarse;
    logic                peak;
    logic [5:0]          pk_pix;
    logic [9:0]          wsample;
    logic [15:0]         cnt;
    bwc_pkg::bwc_phase_t phase;
  } bwc_state_t;

  bwc_state_t r_q;
  bwc_state_t r_d;
  logic       trig;
  logic       wr;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    r_d  = r_q;
    wr   = REQ.we;
    // Trigger pin choice per line
    trig = r_q.wcfg[bwc_pkg::BIT_TRIG_SEL] ? PINS.black_clamp_pin
                                           : PINS.line_clamp_pin;
    // Register writes; reserved bits are held at zero
    if (wr)
    begin
      case (REQ.addr)
        bwc_pkg::OFS_CLAMP:   r_d.clamp = REQ.wdata;
        // High half is only staged, so a lone write leaves FINE_STEP unchanged
        bwc_pkg::OFS_THR_HI:  r_d.thr_hi = REQ.wdata;
        bwc_pkg::OFS_THR_LO:  r_d.thr = {r_q.thr_hi, REQ.wdata[7:6]};
        bwc_pkg::OFS_FAST:    r_d.fast = REQ.wdata;
        bwc_pkg::OFS_WCFG:    r_d.wcfg = REQ.wdata & bwc_pkg::WCFG_MASK;
        bwc_pkg::OFS_RUN_AVG: r_d.run_avg = REQ.wdata[2:0];
        bwc_pkg::OFS_ST_HI:   r_d.st_hi = REQ.wdata;
        bwc_pkg::OFS_ST_LO:   r_d.st = {r_q.st_hi, REQ.wdata};
        bwc_pkg::OFS_WID_HI:  r_d.wid_hi = REQ.wdata;
        bwc_pkg::OFS_WID_LO:  r_d.wid = {r_q.wid_hi, REQ.wdata};
        default:              r_d.rdata = r_q.rdata;
      endcase
    end
    // Loop done clears enable, but a same-cycle write of 1 wins
    if (LOOP_DONE && !(wr && REQ.addr == bwc_pkg::OFS_WCFG
                       && REQ.wdata[bwc_pkg::BIT_ENABLE]))
      r_d.wcfg[bwc_pkg::BIT_ENABLE] = 1'b0;
    // Read data; unmapped offsets read zero
    if (REQ.re)
    begin
      case (REQ.addr)
        bwc_pkg::OFS_CLAMP:   r_d.rdata = r_q.clamp;
        bwc_pkg::OFS_THR_HI:  r_d.rdata = r_q.thr_hi;
        bwc_pkg::OFS_THR_LO:  r_d.rdata = {r_q.thr[1:0], 6'h00};
        bwc_pkg::OFS_FAST:    r_d.rdata = r_q.fast;
        bwc_pkg::OFS_WCFG:    r_d.rdata = r_q.wcfg;
        bwc_pkg::OFS_RUN_AVG: r_d.rdata = {5'h00, r_q.run_avg};
        bwc_pkg::OFS_ST_HI:   r_d.rdata = r_q.st_hi;
        bwc_pkg::OFS_ST_LO:   r_d.rdata = r_q.st[7:0];
        bwc_pkg::OFS_WID_HI:  r_d.rdata = r_q.wid_hi;
        bwc_pkg::OFS_WID_LO:  r_d.rdata = r_q.wid[7:0];
        default:              r_d.rdata = 8'h00;
      endcase
    end
    // Loop runs on enable bit, or while the start pin is high and bit 4 is clear
    r_d.run = r_q.wcfg[bwc_pkg::BIT_ENABLE] ||
              (PINS.white_loop_start &&
               !r_q.wcfg[bwc_pkg::BIT_PIN_DIS]);
    r_d.coarse = !BLK_FINE_ONLY;
    // Codes above 5 saturate at the longest average
    r_d.pk_pix = (r_q.run_avg > bwc_pkg::RUN_AVG_MAX) ? 6'h20
               : 6'(6'h01 << r_q.run_avg);
    // Black offset removal, clamped at zero to avoid wraparound
    if (r_q.wcfg[bwc_pkg::BIT_USE_BLK])
      r_d.wsample = (SAMPLE_IN > BLACK_AVG) ? 10'(SAMPLE_IN - BLACK_AVG)
                                            : 10'h000;
    else
      r_d.wsample = SAMPLE_IN;
    // Peak window sequencer, counted in pixel strobes
    r_d.trig_d = trig;
    case (r_q.phase)
      bwc_pkg::PK_IDLE:
      begin
        r_d.cnt = 16'h0000;
      end
      bwc_pkg::PK_WAIT:
      begin
        if (PINS.pix_en)
        begin
          if (r_q.cnt == r_q.st)
          begin
            r_d.cnt   = 16'h0000;
            r_d.phase = (r_q.wid == 16'h0000) ? bwc_pkg::PK_IDLE
                                              : bwc_pkg::PK_WINDOW;
          end
          else
            r_d.cnt = 16'(r_q.cnt + 16'h0001);
        end
      end
      bwc_pkg::PK_WINDOW:
      begin
        if (PINS.pix_en)
        begin
          if (r_q.cnt == 16'(r_q.wid - 16'h0001))
            r_d.phase = bwc_pkg::PK_IDLE;
          else
            r_d.cnt = 16'(r_q.cnt + 16'h0001);
        end
      end
      default:
        r_d.phase = bwc_pkg::PK_IDLE;
    endcase
    // A new trigger edge restarts the count for this line
    if (r_q.run && trig && !r_q.trig_d)
    begin
      r_d.phase = bwc_pkg::PK_WAIT;
      r_d.cnt   = 16'h0000;
    end
    if (!r_q.run)
      r_d.phase = bwc_pkg::PK_IDLE;
    r_d.peak = (r_d.phase == bwc_pkg::PK_WINDOW);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      r_q         <= '0;
      r_q.clamp   <= bwc_pkg::RST_CLAMP;
      r_q.thr_hi  <= bwc_pkg::RST_THR_HI;
      r_q.thr     <= {bwc_pkg::RST_THR_HI, bwc_pkg::RST_THR_LO[7:6]};
      r_q.fast    <= bwc_pkg::RST_FAST;
      r_q.wcfg    <= bwc_pkg::RST_WCFG;
      r_q.run_avg <= bwc_pkg::RST_RUN_AVG[2:0];
      r_q.st_hi   <= bwc_pkg::RST_ST;
      r_q.wid_hi  <= bwc_pkg::RST_WID;
      r_q.coarse  <= 1'b1;
      r_q.pk_pix  <= 6'(6'h01 << bwc_pkg::RST_RUN_AVG[2:0]);
      r_q.phase   <= bwc_pkg::PK_IDLE;
    end
    else if (CE)
      r_q <= r_d;
  end

  // Outputs come straight from state flops
  assign RDATA           = r_q.rdata;
  assign CLAMP_AVG_CODE  = r_q.clamp[7:3];
  assign FINE_STEP       = r_q.thr;
  assign FAST_HYST       = r_q.fast[7:5];
  assign FAST_THRESH     = r_q.fast[4:0];
  assign INCR_SEARCH     = r_q.wcfg[bwc_pkg::BIT_INCR];
  assign UPDATE_COARSE   = r_q.coarse;
  assign WHITE_LOOP_RUN  = r_q.run;
  assign PEAK_AVG_PIXELS = r_q.pk_pix;
  assign PEAK_ACTIVE     = r_q.peak;
  assign WHITE_SAMPLE    = r_q.wsample;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_thr_commit;
    CE && REQ.we && REQ.addr == bwc_pkg::OFS_THR_LO |=>
      FINE_STEP == {$past(r_q.thr_hi), $past(REQ.wdata[7:6])};
  endproperty
  a_thr_commit: assert property (p_thr_commit)
    else $error("threshold not combined from both halves");

  property p_thr_hold;
    CE && REQ.we && REQ.addr == bwc_pkg::OFS_THR_HI |=> $stable(FINE_STEP);
  endproperty
  a_thr_hold: assert property (p_thr_hold)
    else $error("threshold changed on high half alone");

  property p_pin_run;
    CE && PINS.white_loop_start && !r_q.wcfg[bwc_pkg::BIT_PIN_DIS]
      |=> WHITE_LOOP_RUN;
  endproperty
  a_pin_run: assert property (p_pin_run)
    else $error("start pin did not run loop");

  property p_pin_ignored;
    CE && r_q.wcfg[bwc_pkg::BIT_PIN_DIS] && !r_q.wcfg[bwc_pkg::BIT_ENABLE]
      |=> !WHITE_LOOP_RUN;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored)
    else $error("disabled start pin still ran loop");

  property p_enable_set;
    CE && REQ.we && REQ.addr == bwc_pkg::OFS_WCFG && REQ.wdata[0]
      |=> r_q.wcfg[bwc_pkg::BIT_ENABLE];
  endproperty
  a_enable_set: assert property (p_enable_set)
    else $error("enable write lost");

  property p_pk_avg;
    CE && r_q.run_avg <= bwc_pkg::RUN_AVG_MAX
      |=> PEAK_AVG_PIXELS == 6'(6'h01 << $past(r_q.run_avg));
  endproperty
  a_pk_avg: assert property (p_pk_avg)
    else $error("peak average count wrong");

  property p_no_offset;
    CE && !r_q.wcfg[bwc_pkg::BIT_USE_BLK] |=> WHITE_SAMPLE == $past(SAMPLE_IN);
  endproperty
  a_no_offset: assert property (p_no_offset)
    else $error("black offset applied while off");

  property p_coarse;
    CE |=> UPDATE_COARSE == !$past(BLK_FINE_ONLY);
  endproperty
  a_coarse: assert property (p_coarse)
    else $error("coarse update flag wrong");

  property p_win_open;
    CE && r_q.run && r_q.phase == bwc_pkg::PK_WAIT && PINS.pix_en
      && r_q.cnt == r_q.st && r_q.wid != 16'h0000
      && !(trig && !r_q.trig_d) |=> PEAK_ACTIVE;
  endproperty
  a_win_open: assert property (p_win_open)
    else $error("peak window did not open at start pixel");

endmodule : bwc_ctrl

//--- bwc_host.sv
// Host timing controller model: trigger pulses and pixel strobes
`timescale 1ns/10ps
module bwc_host (
  input  wire logic          CLK,
  input  wire logic          RST_N,
  input  wire logic          FIRE,
  input  wire logic          SEL,
  input  wire logic          HOLD,
  output bwc_pkg::bwc_pins_t PINS
);
  // Pins settle at the first edge, while the bank is still in reset
  logic ph_q = 1'b0;

  // Strobe every other cycle; held back while a trigger rises so the
  // two never share an edge and the start count stays unambiguous
  always @(posedge CLK)
  begin
    ph_q                  <= RST_N & ~ph_q;
    PINS.pix_en           <= RST_N & ph_q & ~FIRE;
    PINS.line_clamp_pin   <= FIRE & ~SEL;
    PINS.black_clamp_pin  <= FIRE & SEL;
    PINS.white_loop_start <= HOLD;
  end
endmodule : bwc_host

//--- bwc_ctrl_tb.sv
// Self-checking bench for the calibration control bank
`timescale 1ns/10ps
module bwc_ctrl_tb;
  logic               clk = 0, rst_n = 0, ce = 1, done = 0, fine = 0;
  logic               fire = 0, sel = 0, hold = 0, incr, upd, run, pk_act;
  bwc_pkg::bwc_req_t  req = '0;
  bwc_pkg::bwc_pins_t pins;
  logic [9:0]         smp = '0, bavg = '0, step, wsmp;
  logic [7:0]         rdata;
  logic [4:0]         avg_code, thr;
  logic [2:0]         hyst;
  logic [5:0]         pk_pix;
  int                 errors = 0, checks_done = 0, pre = 0, inw = 0;
  logic [7:0]         dflt [10] = '{8'h84, 8'h50, 8'h40, 8'h88, 8'h00,
                                    8'h04, 8'h00, 8'h00, 8'h00, 8'h00};

  bwc_ctrl dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .REQ(req), .PINS(pins),
    .LOOP_DONE(done), .BLK_FINE_ONLY(fine), .SAMPLE_IN(smp),
    .BLACK_AVG(bavg), .RDATA(rdata), .CLAMP_AVG_CODE(avg_code),
    .FINE_STEP(step), .FAST_HYST(hyst), .FAST_THRESH(thr),
    .INCR_SEARCH(incr), .UPDATE_COARSE(upd), .WHITE_LOOP_RUN(run),
    .PEAK_AVG_PIXELS(pk_pix), .PEAK_ACTIVE(pk_act), .WHITE_SAMPLE(wsmp));

  bwc_host host (.CLK(clk), .RST_N(rst_n), .FIRE(fire), .SEL(sel),
    .HOLD(hold), .PINS(pins));

  always #50 clk = ~clk;

  // ------------------------------------------------------------
  // Strobe counts before and inside each peak window
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    if (pins.line_clamp_pin | pins.black_clamp_pin)
    begin
      pre = 0;
      inw = 0;
    end
    else if (pk_act)
      inw += pins.pix_en;
    else if (inw == 0)
      pre += pins.pix_en;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic print_verdict;
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Lets registered outputs settle past the edge before sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
    tick(2);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    tick(1);
    chk(rdata, e);
  endtask : rd

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk(rdata, 8'h00);
    chk(step, 10'd321);
    chk(avg_code, 5'h10);
    chk(hyst, 3'h4);
    chk(thr, 5'h08);
    chk(upd, 1'b1);
    chk(pk_pix, 6'h10);
    for (int i = 0; i < 10; i++)
      rd(8'h24 + i[7:0], dflt[i]);
  endtask : t_reset

  task automatic t_fields;
    wr(8'h24, 8'hf9);
    chk(avg_code, 5'h1f);
    wr(8'h27, 8'ha3);
    chk(hyst, 3'h5);
    chk(thr, 5'h03);
    wr(8'h28, 8'hfe);
    rd(8'h28, 8'hf0);
    chk(incr, 1'b1);
    wr(8'h28, 8'h00);
    chk(incr, 1'b0);
    wr(8'h26, 8'hff);
    rd(8'h26, 8'hc0);
    chk(step, 10'd323);
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00);
  endtask : t_fields

  // Half-written values must not reach the loop
  task automatic t_split;
    wr(8'h25, 8'h4e);
    chk(step, 10'd323);
    rd(8'h25, 8'h4e);
    wr(8'h26, 8'h80);
    chk(step, 10'd314);
    wr(8'h25, 8'h2e);
    wr(8'h26, 8'h00);
    chk(step, 10'd184);
  endtask : t_split

  task automatic t_avg;
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h29, c[7:0]);
      chk(pk_pix, (c > 5) ? 6'h20 : 6'h01 << c);
    end
    wr(8'h29, 8'hfd);
    rd(8'h29, 8'h05);
  endtask : t_avg

  task automatic t_misc;
    @(posedge clk);
    smp  <= 10'd300;
    bavg <= 10'd100;
    fine <= 1'b1;
    tick(3);
    chk(wsmp, 10'd300);
    chk(upd, 1'b0);
    wr(8'h28, 8'h40);
    chk(wsmp, 10'd200);
    @(posedge clk);
    bavg <= 10'd400;
    fine <= 1'b0;
    tick(3);
    chk(wsmp, 10'd0);
    chk(upd, 1'b1);
  endtask : t_misc

  task automatic t_run;
    wr(8'h28, 8'h01);
    rd(8'h28, 8'h01);
    chk(run, 1'b1);
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    rd(8'h28, 8'h00);
    chk(run, 1'b0);
    @(posedge clk);
    hold <= 1'b1;
    tick(3);
    chk(run, 1'b1);
    wr(8'h28, 8'h10);
    chk(run, 1'b0);
    @(posedge clk);
    hold <= 1'b0;
  endtask : t_run

  task automatic trig(input logic s, input int p, input int w);
    @(posedge clk);
    sel  <= s;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    tick(40);
    if (w > 0)
      chk(pre, p);
    chk(inw, w);
  endtask : trig

  task automatic t_peak;
    wr(8'h2a, 8'h00);
    wr(8'h2b, 8'h03);
    wr(8'h2c, 8'h00);
    wr(8'h2d, 8'h04);
    trig(1'b0, 0, 0);
    wr(8'h28, 8'h01);
    trig(1'b0, 4, 4);
    wr(8'h28, 8'h21);
    trig(1'b1, 4, 4);
    trig(1'b0, 0, 0);
  endtask : t_peak

  // Enable low freezes the bank; reset still acts through it
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h24, 8'h00);
    chk(avg_code, 5'h1f);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    chk(avg_code, 5'h10);
    chk(pk_pix, 6'h10);
    chk(step, 10'd321);
    @(posedge clk);
    ce <= 1'b1;
  endtask : t_freeze

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_fields();
    t_split();
    t_avg();
    t_misc();
    t_run();
    t_peak();
    t_freeze();
    print_verdict();
  end

  // Whole run needs well under 2000 cycles
  initial
  begin
    #2000000;
    errors++;
    print_verdict();
  end
endmodule : bwc_ctrl_tb
